// File: jtl_link_tx.sv
// Purpose: transmit link alignment: comma stream, lane alignment sequence, alignment characters, 64b/66b headers
// Assumes: sync_n_i and sysref_i come from pins; data_i and blk_i come from logic on core_clk_i
// Notes:   blk_i is already scrambled; char_o feeds the 8b/10b encoder; blk_o[65:64] is the header
`timescale 1ns/1ps

// How it works
// - sync low sends continuous comma characters
// - after sync rises wait for multiframe edge
// - four multiframes, start R, end A
// - second multiframe carries configuration octets
// - repeated last octet becomes F or A
// - scrambled fc becomes F, 7c becomes A
// - scrambled block gets two-bit header first
// - 32-block multiblock, E multiblocks extended
// - sysref resets extended multiblock phase
// - header 01 sends one, 10 zero
// - stream ends with 00001 pilot
// - bit 22 marks last multiblock
// - only crc-12 or fec content offered
// - mode 0 selects crc-12
// - mode 2 selects fec parity
// - sysref resets multiframe phase
module jtl_link_tx
#(
  parameter int F = 2,
  parameter int K = 32,
  parameter int E = 1
)
(
  // clock and reset
  input  wire logic                           core_clk_i,
  input  wire logic                           rst_n_i,
  input  wire logic                           clk_en_i,
  // pins
  input  wire logic                           sync_n_i,
  input  wire logic                           sysref_i,
  // configuration
  input  wire logic                           mode_64b66b_i,
  input  wire logic                           scramble_en_i,
  input  wire logic [1:0]                     sync_header_mode_select_i,
  input  wire logic [jtl_pkg::CFG_OCTETS*8-1:0] ilas_cfg_i,
  // 8b/10b side
  input  wire logic [7:0]                     data_i,
  output logic                                data_take_o,
  output jtl_pkg::jtl_char_s                  char_o,
  // 64b/66b side
  input  wire logic [63:0]                    blk_i,
  input  wire logic [25:0]                    par_i,
  output logic                                blk_take_o,
  output logic [65:0]                         blk_o,
  output logic                                blk_vld_o
);

  // ****************************************
  // state
  // ****************************************
  jtl_pkg::jtl_reg_s q;
  jtl_pkg::jtl_reg_s d;

  logic        ref_edge;
  logic [7:0]  oct_pos;
  logic [7:0]  frm_pos;
  logic [4:0]  blk_pos;
  logic [7:0]  emb_pos;
  logic        frm_end;
  logic        mf_end;
  logic        mf_start;
  logic        eoemb;
  logic [15:0] lin;
  logic [25:0] par_cur;
  logic [1:0]  hdr;

  // ****************************************
  // frame and multiblock phase
  // ****************************************
  // sysref restarts both clocks with the current cycle as phase zero
  assign ref_edge = q.ref_s & ~q.ref_p;
  assign oct_pos  = ref_edge ? 8'h00 : q.oct_cnt;
  assign frm_pos  = ref_edge ? 8'h00 : q.frm_cnt;
  assign blk_pos  = ref_edge ? 5'h00 : q.blk_cnt;
  assign emb_pos  = ref_edge ? 8'h00 : q.emb_cnt;
  assign frm_end  = oct_pos == 8'(F - 1);
  assign mf_end   = frm_end && (frm_pos == 8'(K - 1));
  assign mf_start = (oct_pos == 8'h00) && (frm_pos == 8'h00);
  assign eoemb    = emb_pos == 8'(E - 1);
  assign lin      = 16'(frm_pos * F) + 16'(oct_pos);
  // parity of the previous multiblock is taken at block 0 and held
  assign par_cur  = (blk_pos == 5'h00) ? par_i : q.par;

  jtl_sh_enc u_sh_enc
  (
    .mode_i  (sync_header_mode_select_i),
    .idx_i   (blk_pos),
    .eoemb_i (eoemb),
    .par_i   (par_cur),
    .hdr_o   (hdr)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    d = q;
    if (clk_en_i)
    begin
      d.sync_m  = sync_n_i;
      d.sync_s  = q.sync_m;
      d.ref_m   = sysref_i;
      d.ref_s   = q.ref_m;
      d.ref_p   = q.ref_s;
      d.oct_cnt = frm_end ? 8'h00 : 8'(oct_pos + 8'h01);
      d.frm_cnt = mf_end ? 8'h00 : (frm_end ? 8'(frm_pos + 8'h01) : frm_pos);
      d.blk_cnt = 5'(blk_pos + 5'h01);
      d.emb_cnt = (blk_pos == jtl_pkg::MB_LAST_BLK) ? (eoemb ? 8'h00 : 8'(emb_pos + 8'h01)) : emb_pos;
      if (blk_pos == 5'h00)
        d.par = par_i;
      if (mode_64b66b_i)
      begin
        d.st      = jtl_pkg::ST_CGS;
        d.blk     = {hdr, blk_i};
        d.blk_vld = 1'b1;
      end
      else
      begin
        d.blk_vld = 1'b0;
        if (!q.sync_s)
        begin
          d.st = jtl_pkg::ST_CGS;
          d.ch = '{k: 1'b1, d: jtl_pkg::CH_COMMA};
        end
        else
        begin
          unique case (q.st)
            jtl_pkg::ST_CGS:
            begin
              d.ch = '{k: 1'b1, d: jtl_pkg::CH_COMMA};
              d.st = jtl_pkg::ST_WAIT;
            end
            jtl_pkg::ST_WAIT:
            begin
              d.ch = '{k: 1'b1, d: jtl_pkg::CH_COMMA};
              if (mf_start)
              begin
                d.ch      = '{k: 1'b1, d: jtl_pkg::CH_MF_START};
                d.st      = jtl_pkg::ST_ILAS;
                d.ilas_mf = 2'h0;
              end
            end
            jtl_pkg::ST_ILAS:
            begin
              d.ch = '{k: 1'b0, d: lin[7:0]};
              if (mf_start)
                d.ch = '{k: 1'b1, d: jtl_pkg::CH_MF_START};
              else if (mf_end)
                d.ch = '{k: 1'b1, d: jtl_pkg::CH_MF_END};
              else if (q.ilas_mf == jtl_pkg::ILAS_CFG_MF && lin == 16'h0001)
                d.ch = '{k: 1'b1, d: jtl_pkg::CH_CFG_MARK};
              else if (q.ilas_mf == jtl_pkg::ILAS_CFG_MF && lin >= 16'h0002 && lin < 16'(jtl_pkg::CFG_OCTETS + 2))
                d.ch = '{k: 1'b0, d: ilas_cfg_i[(lin - 16'h0002) * 8 +: 8]};
              if (mf_end)
              begin
                d.ilas_mf = 2'(q.ilas_mf + 2'h1);
                if (q.ilas_mf == jtl_pkg::ILAS_LAST_MF)
                  d.st = jtl_pkg::ST_DATA;
              end
            end
            jtl_pkg::ST_DATA:
            begin
              d.ch = '{k: 1'b0, d: data_i};
              if (frm_end)
              begin
                d.last_oct = data_i;
                if (!scramble_en_i && data_i == q.last_oct)
                  d.ch = '{k: 1'b1, d: mf_end ? jtl_pkg::CH_MF_END : jtl_pkg::CH_FRAME_END};
                else if (scramble_en_i && mf_end && data_i == jtl_pkg::SCR_MF_OCT)
                  d.ch = '{k: 1'b1, d: jtl_pkg::CH_MF_END};
                else if (scramble_en_i && data_i == jtl_pkg::SCR_FRAME_OCT)
                  d.ch = '{k: 1'b1, d: jtl_pkg::CH_FRAME_END};
              end
            end
          endcase
        end
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      q <= '{st: jtl_pkg::ST_CGS, ch: '{k: 1'b1, d: jtl_pkg::CH_COMMA}, default: '0};
    else
      q <= d;
  end

  // ****************************************
  // outputs
  // ****************************************
  // data is pulled only while frames flow, so the source sees real back-pressure
  assign data_take_o = clk_en_i & ~mode_64b66b_i & q.sync_s & (q.st == jtl_pkg::ST_DATA);
  assign blk_take_o  = clk_en_i & mode_64b66b_i;
  assign char_o      = q.ch;
  assign blk_o       = q.blk;
  assign blk_vld_o   = q.blk_vld;

  // ****************************************
  // checks
  // ****************************************
  cgs_comma_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (clk_en_i && !mode_64b66b_i && !q.sync_s) |=> (char_o.k && char_o.d == jtl_pkg::CH_COMMA))
    else $error("comma not sent while sync low");

  ilas_start_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (clk_en_i && !mode_64b66b_i && q.sync_s && q.st == jtl_pkg::ST_WAIT) |=>
    (char_o.d == jtl_pkg::CH_MF_START) == $past(mf_start))
    else $error("alignment sequence started off the multiframe edge");

  ilas_end_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (clk_en_i && !mode_64b66b_i && q.sync_s && q.st == jtl_pkg::ST_ILAS && mf_end) |=>
    (char_o.k && char_o.d == jtl_pkg::CH_MF_END))
    else $error("multiframe of alignment sequence not closed by A");

  ilas_cfg_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (clk_en_i && !mode_64b66b_i && q.sync_s && q.st == jtl_pkg::ST_ILAS && q.ilas_mf == 2'h1 && lin == 16'h0001)
    |=> (char_o.k && char_o.d == jtl_pkg::CH_CFG_MARK))
    else $error("configuration marker missing");

  frame_repeat_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (data_take_o && !scramble_en_i && frm_end && !mf_end && data_i == q.last_oct) |=>
    (char_o.k && char_o.d == jtl_pkg::CH_FRAME_END))
    else $error("repeated frame octet not replaced by F");

  frame_scr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (data_take_o && scramble_en_i && frm_end && data_i == jtl_pkg::SCR_FRAME_OCT) |=> char_o.k)
    else $error("scrambled fc octet not replaced");

  hdr_comp_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    blk_vld_o |-> (blk_o[65] != blk_o[64]))
    else $error("sync header bits not complementary");

  pilot_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (blk_take_o && blk_pos >= jtl_pkg::SHS_PIL_ZERO && blk_pos != jtl_pkg::MB_LAST_BLK) |=>
    (blk_o[65:64] == jtl_pkg::HDR_ZERO))
    else $error("pilot zero missing");

  eoemb_hdr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (blk_take_o && blk_pos == jtl_pkg::SHS_EOEMB_BIT) |=>
    (blk_o[65:64] == ($past(eoemb) ? jtl_pkg::HDR_ONE : jtl_pkg::HDR_ZERO)))
    else $error("end of extended multiblock bit wrong");

  sysref_phase_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (clk_en_i && ref_edge) |=> (q.blk_cnt == 5'h01 && q.emb_cnt == 8'h00))
    else $error("sysref did not reset the block phase");

  ilas_seen_c:  cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    q.st == jtl_pkg::ST_ILAS ##1 q.st == jtl_pkg::ST_DATA);
  a_subst_c:    cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    q.st == jtl_pkg::ST_DATA && char_o.k && char_o.d == jtl_pkg::CH_MF_END);
  eoemb_one_c:  cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    blk_take_o && blk_pos == jtl_pkg::SHS_EOEMB_BIT && eoemb);

endmodule

// File: jtl_pkg.sv
// Purpose: shared constants and types for the link alignment transmitter
// Assumes: one lane, one octet per clock in 8b/10b modes, one block per clock in 64b/66b modes
// Notes:   control characters are carried as raw octets with a k flag, ahead of the 8b/10b encoder
package jtl_pkg;

  // ****************************************
  // control characters (k flag set)
  // ****************************************
  localparam logic [7:0] CH_COMMA     = 8'hbc;
  localparam logic [7:0] CH_MF_START  = 8'h1c;
  localparam logic [7:0] CH_MF_END    = 8'h7c;
  localparam logic [7:0] CH_CFG_MARK  = 8'h9c;
  localparam logic [7:0] CH_FRAME_END = 8'hfc;

  // ****************************************
  // scrambled-mode octets that turn into alignment characters
  // ****************************************
  localparam logic [7:0] SCR_FRAME_OCT = 8'hfc;
  localparam logic [7:0] SCR_MF_OCT    = 8'h7c;

  // ****************************************
  // alignment sequence and 64b/66b structure
  // ****************************************
  localparam logic [1:0] ILAS_LAST_MF  = 2'h3;
  localparam logic [1:0] ILAS_CFG_MF   = 2'h1;
  localparam int         CFG_OCTETS    = 14;
  localparam logic [4:0] MB_LAST_BLK   = 5'h1f;
  localparam logic [4:0] SHS_EOEMB_BIT = 5'h16;
  localparam logic [4:0] SHS_PIL_ZERO  = 5'h1b;
  localparam logic [4:0] SHS_CRC_END   = 5'h0e;
  localparam logic [4:0] SHS_FEC_HI    = 5'h15;
  localparam logic [4:0] SHS_FEC_LO    = 5'h17;
  localparam logic [1:0] HDR_ONE       = 2'h1;
  localparam logic [1:0] HDR_ZERO      = 2'h2;

  // ****************************************
  // sync header mode select values
  // ****************************************
  localparam logic [1:0] SHM_CRC12 = 2'h0;
  localparam logic [1:0] SHM_FEC   = 2'h2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ST_CGS, ST_WAIT, ST_ILAS, ST_DATA} jtl_state_e;

  typedef struct packed {
    logic       k;
    logic [7:0] d;
  } jtl_char_s;

  typedef struct packed {
    logic                   sync_m;
    logic                   sync_s;
    logic                   ref_m;
    logic                   ref_s;
    logic                   ref_p;
    jtl_state_e             st;
    logic [7:0]             oct_cnt;
    logic [7:0]             frm_cnt;
    logic [1:0]             ilas_mf;
    logic [7:0]             last_oct;
    jtl_char_s              ch;
    logic [4:0]             blk_cnt;
    logic [7:0]             emb_cnt;
    logic [25:0]            par;
    logic [65:0]            blk;
    logic                   blk_vld;
  } jtl_reg_s;

endpackage

// File: jtl_rx_model.sv
// Purpose: receiver side of the 8b/10b link start-up, drives the sync request
// Assumes: one lane, multiframe of F*K octets, local phase taken from sysref_i
// Notes:   holds sync low while hold_i is high; payload is judged by the bench, not here
`timescale 1ns/1ps
module jtl_rx_model
#(
  parameter int F = 2,
  parameter int K = 10
)
(
  // clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  // control and link
  input  wire logic               hold_i,
  input  wire logic               sysref_i,
  input  wire jtl_pkg::jtl_char_s char_i,
  output logic                    sync_n_o
);
  int unsigned lmfc;
  int unsigned commas;
  logic        ref_q;

  always_ff @(posedge core_clk_i)
  begin
    ref_q <= sysref_i;
    if (!rst_n_i || (sysref_i && !ref_q))
      lmfc <= 0;
    else
      lmfc <= (lmfc + 1) % (F * K);
    // a fresh request restarts the comma count, as after a misalignment
    if (!rst_n_i || hold_i)
    begin
      sync_n_o <= 1'b0;
      commas   <= 0;
    end
    else if (!sync_n_o)
    begin
      if (char_i.k && char_i.d == 8'hbc)
        commas <= commas + 1;
      else
        commas <= 0;
      if (commas >= 4 && lmfc == 0)
        sync_n_o <= 1'b1;
    end
  end
endmodule

// File: jtl_sh_enc.sv
// Purpose: sync header stream bit and 2-bit header for one block of a multiblock
// Assumes: par_i holds the parity of the previous multiblock; crc-12 in bits 11:0
// Notes:   purely combinational; command bits are always zero
`timescale 1ns/1ps
module jtl_sh_enc
(
  // control
  input  wire logic [1:0]  mode_i,
  input  wire logic [4:0]  idx_i,
  input  wire logic        eoemb_i,
  input  wire logic [25:0] par_i,
  // header, bit 1 is sent first
  output logic      [1:0]  hdr_o
);

  // ****************************************
  // stream bit per position
  // ****************************************
  function automatic logic shs_bit(input logic [1:0] m, input logic [4:0] i, input logic e, input logic [25:0] p);
    logic [4:0] k;
    k = 5'(i - (i >> 2));
    if (i == jtl_pkg::MB_LAST_BLK)
      return 1'b1;
    if (i >= jtl_pkg::SHS_PIL_ZERO)
      return 1'b0;
    if (i == jtl_pkg::SHS_EOEMB_BIT)
      return e;
    if (m == jtl_pkg::SHM_FEC)
    begin
      if (i <= jtl_pkg::SHS_FEC_HI)
        return p[5'd25 - i];
      if (i == jtl_pkg::SHS_FEC_LO)
        return p[3];
      return p[5'd26 - i];
    end
    // any other code falls back to crc-12: crc-3 and command channel are not offered
    // fixed ones sit at every fourth position up to 23 and just below the extended-multiblock bit
    if (i[1:0] == 2'h3 || i == 5'(jtl_pkg::SHS_EOEMB_BIT - 5'h01))
      return 1'b1;
    if (i <= jtl_pkg::SHS_CRC_END)
      return p[5'd11 - k];
    return 1'b0;
  endfunction

  // complementary header: 01 carries a one, 10 a zero
  assign hdr_o = shs_bit(mode_i, idx_i, eoemb_i, par_i) ? jtl_pkg::HDR_ONE : jtl_pkg::HDR_ZERO;

endmodule

// File: tb_top.sv
// Purpose: self-checking bench for the link alignment transmitter
// Assumes: F=2, K=10, E=2; constant parity word on par_i
// Notes:   phases are judged relative to the sysref pulse, since pin latency is fixed but hidden
`timescale 1ns/1ps
module tb_top;
  localparam int          F   = 2;
  localparam int          K   = 10;
  localparam int          E   = 2;
  localparam int          MF  = F * K;
  localparam logic [25:0] PAR = 26'h2b4c96d;
  logic                  core_clk_i = 1'b0;
  logic                  rst_n_i = 1'b0;
  logic                  clk_en_i = 1'b1;
  logic                  hold = 1'b1;
  logic                  sync_n;
  logic                  sysref_i = 1'b0;
  logic                  mode_64b66b_i = 1'b0;
  logic                  scramble_en_i = 1'b0;
  logic [1:0]            sync_header_mode_select_i = 2'h0;
  logic [111:0]          ilas_cfg_i;
  logic [7:0]            data_i = 8'h00;
  logic                  data_take_o;
  jtl_pkg::jtl_char_s    char_o;
  logic [63:0]           blk_i = 64'h0;
  logic [25:0]           par_i = PAR;
  logic                  blk_take_o;
  logic [65:0]           blk_o;
  logic                  blk_vld_o;
  int                    mismatches = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;
  int                    t_ref = 0;
  int                    j = 0;
  logic [7:0]            prev_oct = 8'h00;
  int                    d1;
  int                    d2;

  jtl_link_tx #(.F(F), .K(K), .E(E)) dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .sync_n_i(sync_n), .sysref_i(sysref_i), .mode_64b66b_i(mode_64b66b_i), .scramble_en_i(scramble_en_i),
    .sync_header_mode_select_i(sync_header_mode_select_i), .ilas_cfg_i(ilas_cfg_i), .data_i(data_i),
    .data_take_o(data_take_o), .char_o(char_o), .blk_i(blk_i), .par_i(par_i), .blk_take_o(blk_take_o),
    .blk_o(blk_o), .blk_vld_o(blk_vld_o));
  jtl_rx_model #(.F(F), .K(K)) rx (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hold_i(hold),
    .sysref_i(sysref_i), .char_i(char_o), .sync_n_o(sync_n));

  always #2.5 core_clk_i = ~core_clk_i;

  // ****************************************
  // shared helpers
  // ****************************************
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc > 10000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [65:0] seen, input logic [65:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic pulse_ref();
    @(negedge core_clk_i);
    sysref_i = 1'b1;
    t_ref = cyc;
    @(negedge core_clk_i);
    sysref_i = 1'b0;
  endtask

  // expected sync header stream bit at block b of a multiblock
  function automatic logic shb(input int b, input logic eo, input logic [1:0] m);
    if (b == 22)
      return eo;
    if (b == 31)
      return 1'b1;
    if (m == 2'h2)
    begin
      if (b <= 21)
        return PAR[25-b];
      if (b == 23)
        return PAR[3];
      return (b <= 26) ? PAR[26-b] : 1'b0;
    end
    if (b < 16)
      return (b % 4 == 3) ? 1'b1 : PAR[11-(b/4)*3-b%4];
    return (b == 19 || b == 21 || b == 23);
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_cgs();
    pulse_ref();
    repeat (20)
    begin
      @(negedge core_clk_i);
      chk("comma", 66'(char_o), 66'h1bc);
    end
    $display("test comma stream done");
  endtask

  task automatic t_ilas(output int d);
    int         n;
    logic [8:0] e;
    hold = 1'b0;
    n = 0;
    @(negedge core_clk_i);
    while (char_o !== 9'h11c && n < 400)
    begin
      chk("comma before start", 66'(char_o), 66'h1bc);
      @(negedge core_clk_i);
      n++;
    end
    chk("start seen", 66'(n < 400), 66'h1);
    d = (cyc - t_ref) % MF;
    for (int i = 0; i < 4 * MF; i++)
    begin
      if (i % MF == 0)
        e = 9'h11c;
      else if (i % MF == MF - 1)
        e = 9'h17c;
      else if (i == MF + 1)
        e = 9'h19c;
      else if (i >= MF + 2 && i <= MF + 15)
        e = {1'b0, ilas_cfg_i[(i-MF-2)*8+:8]};
      else
        e = {1'b0, 8'(i % MF)};
      chk("alignment sequence", 66'(char_o), 66'(e));
      if (i < 4 * MF - 1)
        @(negedge core_clk_i);
    end
    $display("test alignment sequence done");
  endtask

  task automatic stream(input logic scr, input int cnt);
    int         p;
    logic       fe;
    logic [7:0] was;
    logic [7:0] got;
    logic [8:0] e;
    repeat (cnt)
    begin
      p = (j + 1) % MF;
      fe = (p % F == F - 1);
      chk("take", 66'(data_take_o), 66'h1);
      scramble_en_i = scr;
      if (!scr)
        data_i = (((j + 1) / F) % 3 == 0) ? 8'h33 : 8'h55;
      else if (!fe || (p != MF - 1 && (p / F) % 2 == 1))
        data_i = 8'hfc;
      else
        data_i = 8'h7c;
      was = prev_oct;
      if (fe && !scr && data_i == prev_oct)
        e = (p == MF - 1) ? 9'h17c : 9'h1fc;
      else if (fe && scr && data_i == 8'hfc)
        e = 9'h1fc;
      else if (fe && scr && p == MF - 1)
        e = 9'h17c;
      else
        e = {1'b0, data_i};
      if (fe)
        prev_oct = data_i;
      @(negedge core_clk_i);
      j++;
      chk("octet", 66'(char_o), 66'(e));
      got = (char_o.k && !scr) ? was : char_o.d;
      chk("restored", 66'(got), 66'(data_i));
      chk("k position", 66'(char_o.k && !fe), 66'h0);
    end
  endtask

  task automatic t_frame_rep();
    j = 4 * MF - 1;
    stream(1'b0, 3 * MF);
    $display("test repeated frame ends done");
  endtask

  task automatic t_frame_scr();
    stream(1'b1, 2 * MF);
    $display("test scrambled frame ends done");
  endtask

  task automatic t_realign();
    hold = 1'b1;
    repeat (6) @(negedge core_clk_i);
    chk("comma again", 66'(char_o), 66'h1bc);
    repeat (7) @(negedge core_clk_i);
    pulse_ref();
    t_ilas(d2);
    chk("start phase", 66'(d2), 66'(d1));
    $display("test realignment done");
  endtask

  task automatic t_blocks(input logic [1:0] m, output int o);
    logic [127:0] bits;
    logic         ok;
    mode_64b66b_i = 1'b1;
    sync_header_mode_select_i = m;
    pulse_ref();
    repeat (40) @(negedge core_clk_i);
    for (int c = 0; c < 128; c++)
    begin
      chk("block take", 66'(blk_take_o), 66'h1);
      blk_i = {32'(c), ~32'(c)};
      @(negedge core_clk_i);
      chk("block data", 66'(blk_o[63:0]), 66'(blk_i));
      chk("header", 66'(blk_o[65] ^ blk_o[64]), 66'h1);
      chk("block valid", 66'(blk_vld_o), 66'h1);
      bits[c] = blk_o[64];
    end
    o = -1;
    for (int t = 32 * E - 1; t >= 0; t--)
    begin
      ok = 1'b1;
      for (int c = 0; c < 128; c++)
        if (bits[c] !== shb((c + t) % 32, ((c + t) / 32) % E == E - 1, m))
          ok = 1'b0;
      if (ok)
        o = t;
    end
    chk("stream found", 66'(o >= 0), 66'h1);
    $display("test blocks in mode %0d done", m);
  endtask

  task automatic t_modes();
    int o0;
    int o;
    t_blocks(2'h0, o0);
    t_blocks(2'h2, o);
    chk("block phase", 66'(o), 66'(o0));
    t_blocks(2'h3, o);
    chk("fallback phase", 66'(o), 66'(o0));
  endtask

  task automatic t_freeze();
    logic [65:0] held;
    clk_en_i = 1'b0;
    @(negedge core_clk_i);
    held = blk_o;
    chk("frozen take", 66'(blk_take_o), 66'h0);
    @(negedge core_clk_i);
    chk("frozen block", blk_o, held);
    clk_en_i = 1'b1;
    $display("test clock enable done");
  endtask

  initial
  begin
    for (int n = 0; n < 14; n++)
      ilas_cfg_i[n*8+:8] = 8'h40 + 8'(n);
    repeat (16) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    t_cgs();
    t_ilas(d1);
    t_frame_rep();
    t_frame_scr();
    t_realign();
    t_modes();
    t_freeze();
    wrap_up();
  end
endmodule
